// ===== hdl/rts_map.svh
// Constants of the reset and time-out sequencer: offsets, fields, resets, timing.
// Assumes inclusion by bare name from the top module and the bench.
`ifndef RTS_MAP_SVH
`define RTS_MAP_SVH
// ==========================================================
// Register byte addresses
`define RTS_ADDR_STATUS 32'h0000_0000
`define RTS_ADDR_CONFIG 32'h0000_0004
`define RTS_ADDR_CMD 32'h0000_0008
`define RTS_ADDR_KEEP 32'h0000_000C
`define RTS_ADDR_WORK 32'h0000_0010
// ==========================================================
// Field positions
`define RTS_STAT_TIMEOUT_BIT 0
`define RTS_STAT_PWRDN_BIT 1
`define RTS_STAT_CAUSE_LSB 2
`define RTS_STAT_RESET_BIT 5
`define RTS_STAT_STALL_BIT 6
`define RTS_CMD_SLEEP_BIT 0
// ==========================================================
// Reset values
`define RTS_CONFIG_RESET 4'hF
`define RTS_WORK_RESET 32'h0000_0000
`define RTS_KEEP_RESET 32'h0000_0000
// ==========================================================
// Timing
`define RTS_CLK_KHZ 25000
`define RTS_POWER_UP_TIMER_TIME_MS 72
`define RTS_POWER_UP_TIMER_CYCLES (`RTS_POWER_UP_TIMER_TIME_MS * `RTS_CLK_KHZ)
`define RTS_OST_EDGES 1024
`define RTS_MASTER_CLEAR_N_FILT_NS 2000
`define RTS_MASTER_CLEAR_N_CYCLES ((`RTS_MASTER_CLEAR_N_FILT_NS * `RTS_CLK_KHZ + 999999) / 1000000)
`define RTS_BO_QUAL_US 100
`define RTS_BO_CYCLES ((`RTS_BO_QUAL_US * `RTS_CLK_KHZ + 999) / 1000)
`endif

// ===== hdl/rts_pkg.sv
// Types of the reset and time-out sequencer.
// Assumes the constants come from rts_map.svh.
package rts_pkg;
    // ==========================================================
    // Sequencer states, one-hot
    typedef enum logic [6:0] {
        ST_POR_WAIT = 7'h01,
        ST_BOR_WAIT = 7'h02,
        ST_PWRUP = 7'h04,
        ST_OSC_WAIT = 7'h08,
        ST_RUN = 7'h10,
        ST_SLEEP = 7'h20,
        ST_WD_RST = 7'h40
    } rts_state_t;
    // Cause of the last reset or wake-up
    typedef enum logic [2:0] {
        CAUSE_POR = 3'h0,
        CAUSE_MASTER_RUN = 3'h1,
        CAUSE_MASTER_SLEEP = 3'h2,
        CAUSE_WATCHDOG_RST = 3'h3,
        CAUSE_WATCHDOG_WAKE = 3'h4,
        CAUSE_BROWN_OUT = 3'h5
    } rts_cause_t;
    // Oscillator select codes
    typedef enum logic [1:0] {
        OSC_LOWPOWER = 2'h0,
        OSC_STD = 2'h1,
        OSC_HIGHSPEED = 2'h2,
        OSC_RC = 2'h3
    } rts_osc_t;
    // Configuration word
    typedef struct packed {
        logic brownout_enable;
        logic pwrup_timer_enable_n;
        rts_osc_t osc_select;
    } rts_cfg_t;
endpackage

// ===== hdl/rts_top.sv
// Reset generation, start-up time-outs, reset-cause flags and an AHB-Lite register slave.
// Assumes all inputs synchronous to ref_clk; supply comparators already synchronised.
`timescale 1ns/1ps
`default_nettype none
`include "rts_map.svh"
module rts_top
    import rts_pkg::*;
#(
    parameter int POWER_UP_TIMER_CYCLES = `RTS_POWER_UP_TIMER_CYCLES,
    parameter int OST_EDGES = `RTS_OST_EDGES,
    parameter int MASTER_CLEAR_N_CYCLES = `RTS_MASTER_CLEAR_N_CYCLES,
    parameter int BO_CYCLES = `RTS_BO_CYCLES
) (
    input wire logic ref_clk, // 25 MHz clock
    input wire logic rst, // Synchronous reset, power-on event
    input wire logic hsel, // AHB select
    input wire logic [31:0] haddr, // AHB address
    input wire logic [1:0] htrans, // AHB transfer type
    input wire logic hwrite, // AHB write
    input wire logic [2:0] hsize, // AHB size, word only
    input wire logic hready, // AHB bus ready
    input wire logic [31:0] hwdata, // AHB write data
    output logic hreadyout, // AHB slave ready
    output logic [31:0] hrdata, // AHB read data
    output logic hresp, // AHB response, always OKAY
    input wire logic supply_ok, // Supply adequate level
    input wire logic below_brownout, // Supply below brown-out threshold
    input wire logic master_clear_n, // Master clear, active low
    input wire logic watchdog_timeout, // Watchdog event pulse
    input wire logic osc_in, // External oscillator, sampled
    output logic chip_reset, // Core held in reset
    output logic core_stall, // Core not executing
    output logic osc_out_clock_div4 // Clock out in RC mode
);
    localparam int PW = $clog2(POWER_UP_TIMER_CYCLES + 1);
    localparam int OW = $clog2(OST_EDGES + 1);
    localparam int MW = $clog2(MASTER_CLEAR_N_CYCLES + 1);
    localparam int BW = $clog2(BO_CYCLES + 1);

    rts_state_t state, next_state;
    rts_cause_t cause, next_cause;
    rts_cfg_t cfg, next_cfg;
    logic timeout_flag, next_timeout_flag;
    logic powerdown_flag, next_powerdown_flag;
    logic ost_rst, next_ost_rst;
    logic [PW-1:0] power_up_timer_cnt, next_power_up_timer_cnt;
    logic [OW-1:0] ost_cnt, next_ost_cnt;
    logic [MW-1:0] filt_cnt, next_filt_cnt;
    logic [BW-1:0] bo_cnt, next_bo_cnt;
    logic master_clear_n_low, next_master_clear_n_low;
    logic osc_prev, next_chip_reset, next_core_stall, reg_load;
    logic [1:0] div_cnt, next_div_cnt;
    logic next_div4;
    logic dphase, next_dphase, wr_q, next_wr;
    logic [31:0] addr_q, next_addr, next_hrdata, stat_word;
    logic [31:0] keep, next_keep, work, next_work;
    logic crystal, power_up_timer_on, bo_trip, master_clear_n_rise, osc_rise, sleep_cmd, wr_hit;

    // ==========================================================
    // Configuration decode
    assign crystal = cfg.osc_select != OSC_RC;
    // Brown-out enable forces the timer on whatever its own bit says
    assign power_up_timer_on = !cfg.pwrup_timer_enable_n || cfg.brownout_enable;
    assign osc_rise = osc_in && !osc_prev;
    assign master_clear_n_rise = next_master_clear_n_low && !master_clear_n_low;
    assign bo_trip = bo_cnt == BW'(BO_CYCLES);
    assign wr_hit = dphase && wr_q;
    assign sleep_cmd = wr_hit && addr_q == `RTS_ADDR_CMD && hwdata[`RTS_CMD_SLEEP_BIT];

    // ==========================================================
    // Master clear filter and brown-out qualification
    always_comb begin
        next_filt_cnt = filt_cnt;
        if (master_clear_n) begin
            next_filt_cnt = '0;
        end else if (filt_cnt != MW'(MASTER_CLEAR_N_CYCLES)) begin
            next_filt_cnt = filt_cnt + MW'(1);
        end
        // Low only after MASTER_CLEAR_N_CYCLES low samples in a row; release is immediate
        next_master_clear_n_low = !master_clear_n && (master_clear_n_low || filt_cnt == MW'(MASTER_CLEAR_N_CYCLES - 1));
        next_bo_cnt = '0;
        // Comparator output treated as a plain level
        if (cfg.brownout_enable && below_brownout) begin
            next_bo_cnt = bo_trip ? bo_cnt : bo_cnt + BW'(1);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            filt_cnt <= '0;
            master_clear_n_low <= 1'b0;
            bo_cnt <= '0;
        end else begin
            filt_cnt <= next_filt_cnt;
            master_clear_n_low <= next_master_clear_n_low;
            bo_cnt <= next_bo_cnt;
        end
    end

    // ==========================================================
    // Reset sequencer
    always_comb begin
        next_state = state;
        next_cause = cause;
        next_timeout_flag = timeout_flag;
        next_powerdown_flag = powerdown_flag;
        next_ost_rst = ost_rst;
        next_power_up_timer_cnt = power_up_timer_cnt;
        next_ost_cnt = ost_cnt;
        reg_load = 1'b0;
        unique case (state)
            ST_POR_WAIT: begin
                // Timers start once supply_ok is seen, master clear or not
                if (supply_ok) begin
                    next_power_up_timer_cnt = '0;
                    next_ost_cnt = '0;
                    if (power_up_timer_on) begin
                        next_state = ST_PWRUP;
                    end else if (crystal) begin
                        next_state = ST_OSC_WAIT;
                    end else begin
                        next_state = ST_RUN;
                    end
                end
            end
            ST_BOR_WAIT: begin
                if (!below_brownout) begin
                    next_power_up_timer_cnt = '0;
                    next_state = ST_PWRUP;
                end
            end
            ST_PWRUP: begin
                if (cfg.brownout_enable && below_brownout) begin
                    next_state = ST_BOR_WAIT;
                end else if (power_up_timer_cnt == PW'(POWER_UP_TIMER_CYCLES - 1)) begin
                    next_ost_cnt = '0;
                    next_state = (crystal && ost_rst) ? ST_OSC_WAIT : ST_RUN;
                end else begin
                    next_power_up_timer_cnt = power_up_timer_cnt + PW'(1);
                end
            end
            ST_OSC_WAIT: begin
                if (osc_rise) begin
                    if (ost_cnt == OW'(OST_EDGES - 1)) begin
                        next_state = ST_RUN;
                    end else begin
                        next_ost_cnt = ost_cnt + OW'(1);
                    end
                end
            end
            ST_RUN: begin
                if (master_clear_n_rise) begin
                    next_cause = CAUSE_MASTER_RUN;
                    reg_load = 1'b1;
                end else if (watchdog_timeout) begin
                    next_cause = CAUSE_WATCHDOG_RST;
                    next_timeout_flag = 1'b0;
                    reg_load = 1'b1;
                    next_state = ST_WD_RST;
                end else if (sleep_cmd) begin
                    next_timeout_flag = 1'b1;
                    next_powerdown_flag = 1'b0;
                    next_state = ST_SLEEP;
                end
            end
            ST_SLEEP: begin
                if (master_clear_n_rise) begin
                    next_cause = CAUSE_MASTER_SLEEP;
                    next_timeout_flag = 1'b1;
                    next_powerdown_flag = 1'b0;
                    reg_load = 1'b1;
                    next_state = ST_RUN;
                end else if (watchdog_timeout) begin
                    // Wake is resumption: no register reload
                    next_cause = CAUSE_WATCHDOG_WAKE;
                    next_timeout_flag = 1'b0;
                    next_powerdown_flag = 1'b0;
                    next_ost_rst = 1'b0;
                    next_ost_cnt = '0;
                    next_state = crystal ? ST_OSC_WAIT : ST_RUN;
                end
            end
            ST_WD_RST: begin
                next_state = ST_RUN;
            end
            default: begin
                next_state = ST_POR_WAIT;
            end
        endcase
        // Qualified brown-out overrides; the timer states handle raw dips themselves
        if (bo_trip && !(state inside {ST_POR_WAIT, ST_BOR_WAIT, ST_PWRUP})) begin
            next_state = ST_BOR_WAIT;
            next_cause = CAUSE_BROWN_OUT;
            next_ost_rst = 1'b0;
            reg_load = 1'b1;
        end
        // Reset output combines time-outs with the filtered pin
        next_chip_reset = next_master_clear_n_low || (next_state inside {ST_POR_WAIT, ST_BOR_WAIT,
            ST_PWRUP, ST_WD_RST}) || (next_state == ST_OSC_WAIT && next_ost_rst);
        next_core_stall = next_state != ST_RUN || next_master_clear_n_low;
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state <= ST_POR_WAIT;
            cause <= CAUSE_POR;
            timeout_flag <= 1'b1;
            powerdown_flag <= 1'b1;
            ost_rst <= 1'b1;
            power_up_timer_cnt <= '0;
            ost_cnt <= '0;
            osc_prev <= 1'b0;
            chip_reset <= 1'b1;
            core_stall <= 1'b1;
        end else begin
            state <= next_state;
            cause <= next_cause;
            timeout_flag <= next_timeout_flag;
            powerdown_flag <= next_powerdown_flag;
            ost_rst <= next_ost_rst;
            power_up_timer_cnt <= next_power_up_timer_cnt;
            ost_cnt <= next_ost_cnt;
            osc_prev <= osc_in;
            chip_reset <= next_chip_reset;
            core_stall <= next_core_stall;
        end
    end

    // ==========================================================
    // Divide-by-four of ref_clk as clock output, driven only when RC is selected
    always_comb begin
        next_div_cnt = div_cnt + 2'h1;
        next_div4 = (cfg.osc_select == OSC_RC) ? next_div_cnt[1] : 1'b0;
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            div_cnt <= 2'h0;
            osc_out_clock_div4 <= 1'b0;
        end else begin
            div_cnt <= next_div_cnt;
            osc_out_clock_div4 <= next_div4;
        end
    end

    // ==========================================================
    // AHB-Lite slave, zero wait states; read data registered in the address phase
    always_comb begin
        stat_word = 32'h0000_0000;
        stat_word[`RTS_STAT_TIMEOUT_BIT] = timeout_flag;
        stat_word[`RTS_STAT_PWRDN_BIT] = powerdown_flag;
        stat_word[`RTS_STAT_CAUSE_LSB +: 3] = cause;
        stat_word[`RTS_STAT_RESET_BIT] = chip_reset;
        stat_word[`RTS_STAT_STALL_BIT] = core_stall;
        next_dphase = hsel && htrans[1] && hready;
        next_addr = next_dphase ? haddr : addr_q;
        next_wr = next_dphase && hwrite;
        next_hrdata = 32'h0000_0000;
        if (next_dphase && !hwrite) begin
            unique case (haddr)
                `RTS_ADDR_STATUS: next_hrdata = stat_word;
                `RTS_ADDR_CONFIG: next_hrdata = {28'h000_0000, cfg};
                `RTS_ADDR_KEEP: next_hrdata = keep;
                `RTS_ADDR_WORK: next_hrdata = work;
                default: next_hrdata = 32'h0000_0000;
            endcase
        end
        next_cfg = cfg;
        next_keep = keep;
        next_work = work;
        if (wr_hit && addr_q == `RTS_ADDR_CONFIG) begin
            next_cfg = rts_cfg_t'(hwdata[3:0]);
        end
        // Survives every reset except the power-on one
        if (wr_hit && addr_q == `RTS_ADDR_KEEP) begin
            next_keep = hwdata;
        end
        // A reset reload beats a simultaneous write
        if (reg_load) begin
            next_work = `RTS_WORK_RESET;
        end else if (wr_hit && addr_q == `RTS_ADDR_WORK) begin
            next_work = hwdata;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            dphase <= 1'b0;
            wr_q <= 1'b0;
            addr_q <= 32'h0000_0000;
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            cfg <= rts_cfg_t'(`RTS_CONFIG_RESET);
            keep <= `RTS_KEEP_RESET;
            work <= `RTS_WORK_RESET;
        end else begin
            dphase <= next_dphase;
            wr_q <= next_wr;
            addr_q <= next_addr;
            hrdata <= next_hrdata;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            cfg <= next_cfg;
            keep <= next_keep;
            work <= next_work;
        end
    end

    // ==========================================================
    // Checks
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);

    chk_div4_rc: assert property (
        (cfg.osc_select == OSC_RC) [*4] |-> osc_out_clock_div4 != $past(osc_out_clock_div4, 2))
        else $error("clock output is not a divide by four");
    chk_por_flags: assert property (
        $fell(rst) |-> timeout_flag && powerdown_flag && cause == CAUSE_POR && chip_reset)
        else $error("power-on state wrong");
    chk_wd_clears: assert property (
        state == ST_RUN && watchdog_timeout && !master_clear_n_rise && !bo_trip
        |=> !timeout_flag && state == ST_WD_RST && chip_reset)
        else $error("watchdog reset did not clear the time-out flag");
    chk_sleep_pd: assert property (
        state == ST_RUN && sleep_cmd && !master_clear_n_rise && !watchdog_timeout && !bo_trip
        |=> !powerdown_flag && state == ST_SLEEP)
        else $error("sleep entry did not clear the power-down flag");
    chk_filter_rise: assert property (
        $rose(master_clear_n_low) |-> $past(filt_cnt) == MW'(MASTER_CLEAR_N_CYCLES - 1) && !$past(master_clear_n))
        else $error("master clear accepted too early");
    chk_supply_wait: assert property (
        state == ST_POR_WAIT && !supply_ok |=> state == ST_POR_WAIT && chip_reset)
        else $error("left power-on wait without supply");
    chk_power_up_timer_hold: assert property (
        state == ST_PWRUP |-> chip_reset)
        else $error("reset released while power-up timer runs");
    chk_power_up_timer_restart: assert property (
        state == ST_PWRUP && cfg.brownout_enable && below_brownout |=> state == ST_BOR_WAIT)
        else $error("dip during power-up timer not handled");
    chk_ost_len: assert property (
        state == ST_OSC_WAIT ##1 state == ST_RUN |-> $past(ost_cnt) == OW'(OST_EDGES - 1))
        else $error("start-up count ended early");
    chk_rc_none: assert property (
        state == ST_POR_WAIT && supply_ok && cfg == rts_cfg_t'(4'h7) |=> state == ST_RUN)
        else $error("time-out applied in RC mode without timer");
    chk_no_por_again: assert property (
        state != ST_POR_WAIT |=> state != ST_POR_WAIT)
        else $error("power-on wait re-entered without reset");
endmodule
`default_nettype wire

// ===== bench/rts_far_side.sv
// Far-side model: supply comparators, master clear pin, watchdog source and oscillator.
// Assumes the bench sets the want_* levels by non-blocking assignment after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module rts_far_side (
    input wire logic ref_clk, // Sequencer clock
    input wire logic want_supply, // Requested supply-adequate level
    input wire logic want_below, // Requested below-threshold level
    input wire logic want_master_clear_n_n, // Requested pin level
    input wire logic want_wd, // Requested watchdog pulse
    input wire logic osc_run, // Oscillator running
    output logic supply_ok, // Comparator level
    output logic below_brownout, // Comparator level
    output logic master_clear_n, // Pin level, active low
    output logic watchdog_timeout, // Watchdog event
    output logic osc_in // Oscillator, still while stopped
);
    // ==========================================================
    // Power-up state: supply absent, pin pulled low by the board
    initial begin
        {supply_ok, below_brownout, master_clear_n, watchdog_timeout, osc_in} = 5'h00;
    end
    // Levels move only at edges, as a synchroniser would deliver them
    always @(posedge ref_clk) begin
        supply_ok <= want_supply;
        below_brownout <= want_below;
        master_clear_n <= want_master_clear_n_n;
        watchdog_timeout <= want_wd;
        osc_in <= osc_run & ~osc_in;
    end
endmodule
`default_nettype wire

// ===== bench/test_rts_top.sv
// Self-checking bench for the reset sequencer: AHB-Lite register access and reset sequences.
// Assumes rts_top with shortened counts and the far-side model in rts_far_side.
`timescale 1ns/1ps
`default_nettype none
`include "rts_map.svh"
module test_rts_top
    import rts_pkg::*;
;
    localparam int P = 20;
    localparam int O = 8;
    logic ref_clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, q;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic want_supply = 1'b0, want_below = 1'b0, want_master_clear_n_n = 1'b0, want_wd = 1'b0;
    logic osc_run = 1'b0;
    wire logic hreadyout, hresp, chip_reset, core_stall, div4;
    wire logic supply_ok, below_brownout, master_clear_n, watchdog_timeout, osc_in;
    wire logic [31:0] hrdata;
    int n_errors = 0, n_compared = 0, n, hi, r, lo;
    // ==========================================================
    // Clock and the two parties around the sequencer
    always #20 ref_clk = ~ref_clk;
    rts_top #(.POWER_UP_TIMER_CYCLES(P), .OST_EDGES(O), .MASTER_CLEAR_N_CYCLES(3), .BO_CYCLES(4)) dut (
        .ref_clk(ref_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .supply_ok(supply_ok),
        .below_brownout(below_brownout), .master_clear_n(master_clear_n),
        .watchdog_timeout(watchdog_timeout), .osc_in(osc_in), .chip_reset(chip_reset),
        .core_stall(core_stall), .osc_out_clock_div4(div4));
    rts_far_side far (
        .ref_clk(ref_clk), .want_supply(want_supply), .want_below(want_below),
        .want_master_clear_n_n(want_master_clear_n_n), .want_wd(want_wd), .osc_run(osc_run),
        .supply_ok(supply_ok), .below_brownout(below_brownout),
        .master_clear_n(master_clear_n), .watchdog_timeout(watchdog_timeout), .osc_in(osc_in));
    // ==========================================================
    // Expected status word from flags, cause and core state
    function automatic logic [31:0] st(logic t, logic p, rts_cause_t c, logic rs, logic sl);
        return {25'h0, sl, rs, c, p, t};
    endfunction
    task automatic tick(input int k);
        repeat (k) @(posedge ref_clk);
    endtask
    task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
            n_errors++;
        end
    endtask
    task automatic cmp_span(input int got, input int lo_b, input int hi_b);
        n_compared++;
        if (got < lo_b || got > hi_b) begin
            $display("mismatch at %0t: got %h expected %h..%h", $time, got, lo_b, hi_b);
            n_errors++;
        end
    endtask
    // One single transfer; a slow hreadyout only stretches the waits
    task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d);
        int k;
        k = 0;
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        do begin @(posedge ref_clk); k++; end while (hreadyout !== 1'b1 && k < 50);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do begin @(posedge ref_clk); k++; end while (hreadyout !== 1'b1 && k < 50);
        q = hrdata;
        if (k >= 50) n_errors++;
    endtask
    task automatic chk_reg(input logic [31:0] a, input logic [31:0] exp);
        xfer(a, 1'b0, 32'h0);
        cmp_word(q, exp);
    endtask
    task automatic pulse_master_clear_n(input int k);
        want_master_clear_n_n <= 1'b0;
        tick(k);
        want_master_clear_n_n <= 1'b1;
        tick(4);
    endtask
    task automatic pulse_wd();
        want_wd <= 1'b1;
        tick(1);
        want_wd <= 1'b0;
    endtask
    // Cycles until the core runs; bounded so a stuck sequencer shows as a long span
    task automatic span(output int k);
        k = 0;
        while (core_stall !== 1'b0 && k < 3000) begin @(posedge ref_clk); k++; end
    endtask
    task automatic give_verdict();
        $display("errors %0d compared %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // ==========================================================
    // Watchdog against a hang; the tests need a few hundred cycles
    initial begin
        #(40 * 20000);
        n_errors++;
        give_verdict();
    end
    // Main sequence
    initial begin
        tick(12);
        rst <= 1'b0;
        tick(20);
        cmp_word({31'h0, chip_reset}, 32'h1);
        chk_reg(`RTS_ADDR_STATUS, st(1, 1, CAUSE_POR, 1, 1));
        chk_reg(`RTS_ADDR_CONFIG, {28'h0, `RTS_CONFIG_RESET});
        want_supply <= 1'b1;
        tick(P + 12);
        cmp_word({31'h0, chip_reset}, 32'h1);
        want_master_clear_n_n <= 1'b1;
        tick(4);
        cmp_word({31'h0, chip_reset}, 32'h0);
        chk_reg(`RTS_ADDR_STATUS, st(1, 1, CAUSE_POR, 0, 0));
        hi = 0;
        r = 0;
        // Seed the previous level so exactly eight transitions are judged
        @(posedge ref_clk);
        q[0] = div4;
        for (int i = 0; i < 8; i++) begin
            @(posedge ref_clk);
            hi += div4;
            r += (div4 && !q[0]);
            q[0] = div4;
        end
        cmp_span(hi, 4, 4);
        cmp_span(r, 2, 2);
        // Watchdog reset while running
        xfer(`RTS_ADDR_KEEP, 1'b1, 32'hCAFE_F00D);
        xfer(`RTS_ADDR_WORK, 1'b1, 32'h1234_5678);
        pulse_wd();
        tick(6);
        chk_reg(`RTS_ADDR_STATUS, st(0, 1, CAUSE_WATCHDOG_RST, 0, 0));
        chk_reg(`RTS_ADDR_WORK, 32'h0);
        chk_reg(`RTS_ADDR_KEEP, 32'hCAFE_F00D);
        // Sleep, a filtered glitch, then a real master clear
        xfer(`RTS_ADDR_WORK, 1'b1, 32'h0000_0055);
        xfer(`RTS_ADDR_CMD, 1'b1, 32'h1);
        tick(2);
        chk_reg(`RTS_ADDR_STATUS, st(1, 0, CAUSE_WATCHDOG_RST, 0, 1));
        pulse_master_clear_n(2);
        cmp_word({31'h0, core_stall}, 32'h1);
        pulse_master_clear_n(6);
        chk_reg(`RTS_ADDR_STATUS, st(1, 0, CAUSE_MASTER_SLEEP, 0, 0));
        chk_reg(`RTS_ADDR_WORK, 32'h0);
        // Crystal mode, watchdog wake waits for oscillator edges
        xfer(`RTS_ADDR_CONFIG, 1'b1, 32'h9);
        xfer(`RTS_ADDR_WORK, 1'b1, 32'h0000_0077);
        xfer(`RTS_ADDR_CMD, 1'b1, 32'h1);
        tick(2);
        pulse_wd();
        tick(30);
        cmp_word({30'h0, chip_reset, core_stall}, 32'h1);
        chk_reg(`RTS_ADDR_STATUS, st(0, 0, CAUSE_WATCHDOG_WAKE, 0, 1));
        osc_run <= 1'b1;
        span(n);
        osc_run <= 1'b0;
        cmp_span(n, 2 * O - 2, 2 * O + 4);
        chk_reg(`RTS_ADDR_WORK, 32'h0000_0077);
        cmp_word({31'h0, div4}, 32'h0);
        // Master clear while running: flags untouched, cause recorded
        pulse_master_clear_n(6);
        chk_reg(`RTS_ADDR_STATUS, st(0, 0, CAUSE_MASTER_RUN, 0, 0));
        // Brown-out: short dip ignored, long dip resets, dip in timer restarts it
        want_below <= 1'b1;
        tick(3);
        want_below <= 1'b0;
        tick(4);
        cmp_word({31'h0, chip_reset}, 32'h0);
        want_below <= 1'b1;
        tick(10);
        cmp_word({31'h0, chip_reset}, 32'h1);
        xfer(`RTS_ADDR_STATUS, 1'b0, 32'h0);
        cmp_word(q & 32'h1C, 32'h14);
        want_below <= 1'b0;
        tick(10);
        want_below <= 1'b1;
        tick(1);
        want_below <= 1'b0;
        span(n);
        cmp_span(n, P, P + 5);
        // Power-on with RC no timer, timer enabled, and timer forced by brown-out
        for (int i = 0; i < 3; i++) begin
            want_supply <= 1'b0;
            rst <= 1'b1;
            tick(12);
            rst <= 1'b0;
            tick(2);
            xfer(`RTS_ADDR_CONFIG, 1'b1, (i == 0) ? 32'h7 : (i == 1) ? 32'h3 : 32'hF);
            want_supply <= 1'b1;
            span(n);
            lo = (i == 0) ? 1 : P;
            cmp_span(n, lo, lo + 4);
        end
        give_verdict();
    end
endmodule
`default_nettype wire
